//--- hw/sms_defines.svh
// register offsets, field positions, reset values and codes for the stop mode selector
// assumes word-aligned avalon-mm byte addresses
`ifndef SMS_DEFINES_SVH
`define SMS_DEFINES_SVH
`define SMS_ADDR_W 4
`define SMS_OFF_CFG 4'h0
`define SMS_OFF_STATUS 4'h4
`define SMS_OFF_ACTIVE 4'h8
`define SMS_CFG_UV_BIT 0
`define SMS_CFG_LIM_LO 4
`define SMS_CFG_LIM_HI 5
`define SMS_CFG_PWR_LO 8
`define SMS_CFG_PWR_HI 11
`define SMS_LIM_RST 2'h0
`define SMS_PWR_RST 4'h0
`define SMS_UV_RST 1'h1
`define SMS_LIM_MAX 2'h2
`define SMS_PWR_MAX 4'h9
`define SMS_LIM_DB 2'h0
`define SMS_LIM_FREE 2'h1
`define SMS_LIM_ESTOP 2'h2
`define SMS_PWR_ESTOP_LO 4'h8
`define SMS_PWR_HOLD_BIT 2
`define SMS_PWR_FREE_BIT 1
`define SMS_PWR_DECEL_BIT 0
`define SMS_PWR_ESTOP9 4'h9
`define SMS_ALARM_UV 8'h0d
`define SMS_ALARM_NONE 8'h00
`endif

//--- hw/sms_pkg.sv
// types for the stop mode selector
// assumes sms_defines.svh is on the include path
package sms_pkg;
	typedef enum logic [1:0] {
		SMS_RUN = 2'b00,
		SMS_DECEL = 2'b01,
		SMS_STOPPED = 2'b10
	} sms_state_t;
	typedef struct packed {
		logic dyn_brake;
		logic fwd_torque_off;
		logic rev_torque_off;
		logic torque_off;
		logic estop;
		logic dev_clear;
		logic dev_hold;
	} sms_ctl_t;
endpackage : sms_pkg

//--- hw/sms_stop_sel.sv
// stop mode selector for drive-prohibit inputs and main power loss
// assumes synchronous inputs, avalon-mm master honouring waitrequest
`include "sms_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module sms_stop_sel (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [`SMS_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// drive inputs
	input wire logic fwd_limit_in,
	input wire logic rev_limit_in,
	input wire logic main_power_lost,
	input wire logic motor_stopped,
	input wire logic power_cycle,
	// stop controls
	output var sms_pkg::sms_ctl_t ctl,
	output logic [7:0] alarm_code
);

////////////////////////////////////////////////////////////////////////////////
// registers

logic uv_alarm_select;
logic [1:0] limit_stop_select;
logic [1:0] limit_stop_pending;
logic [3:0] power_off_stop_select;
wire ack = ~avs_waitrequest;
sms_pkg::sms_state_t state;
sms_pkg::sms_state_t next_state;
sms_pkg::sms_ctl_t next_ctl;
logic [7:0] next_alarm;

////////////////////////////////////////////////////////////////////////////////
// bus decode

wire req = avs_read | avs_write;
wire wr_cfg = avs_write & ack & (avs_address == `SMS_OFF_CFG);
wire [1:0] wr_lim = avs_writedata[`SMS_CFG_LIM_HI:`SMS_CFG_LIM_LO];
wire [3:0] wr_pwr = avs_writedata[`SMS_CFG_PWR_HI:`SMS_CFG_PWR_LO];
wire lim_ok = wr_lim <= `SMS_LIM_MAX;
wire pwr_ok = wr_pwr <= `SMS_PWR_MAX;
wire [31:0] cfg_word = {20'h0_0000, power_off_stop_select, 2'h0, limit_stop_select,
	3'h0, uv_alarm_select};
wire [31:0] status_word = {24'h00_0000, alarm_code};
wire [31:0] active_word = {23'h00_0000, limit_stop_pending, 4'h0, state, ctl.estop};
wire [31:0] rd_word = (avs_address == `SMS_OFF_CFG) ? cfg_word :
	(avs_address == `SMS_OFF_STATUS) ? status_word :
	(avs_address == `SMS_OFF_ACTIVE) ? active_word : 32'h0000_0000;

always_ff @(posedge clk) begin
	if (rst) begin
		avs_waitrequest <= 1'b1;
		avs_readdata <= 32'h0000_0000;
	end else begin
		avs_waitrequest <= ~(req & avs_waitrequest);
		if (avs_read & avs_waitrequest) begin
			avs_readdata <= rd_word;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// settings

always_ff @(posedge clk) begin
	if (rst) begin
		uv_alarm_select <= `SMS_UV_RST;
		limit_stop_select <= `SMS_LIM_RST;
		limit_stop_pending <= `SMS_LIM_RST;
		power_off_stop_select <= `SMS_PWR_RST;
	end else begin
		if (wr_cfg) begin
			uv_alarm_select <= avs_writedata[`SMS_CFG_UV_BIT];
			if (lim_ok) begin
				limit_stop_pending <= wr_lim;
			end
			if (pwr_ok) begin
				power_off_stop_select <= wr_pwr;
			end
		end
		if (power_cycle) begin
			limit_stop_select <= limit_stop_pending;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// stop decoding

wire fwd_hit = fwd_limit_in;
wire rev_hit = rev_limit_in;
wire limit_hit = fwd_hit | rev_hit;
wire pwr_stop = main_power_lost & ~uv_alarm_select;
wire uv_alarm = main_power_lost & uv_alarm_select;
wire pwr_estop = power_off_stop_select >= `SMS_PWR_ESTOP_LO;
wire pwr_decel_db = ~pwr_estop & ~power_off_stop_select[`SMS_PWR_DECEL_BIT];
wire pwr_after_free = pwr_estop ? (power_off_stop_select == `SMS_PWR_ESTOP9) :
	power_off_stop_select[`SMS_PWR_FREE_BIT];
wire pwr_hold = ~pwr_estop & power_off_stop_select[`SMS_PWR_HOLD_BIT];
wire lim_db = limit_stop_select == `SMS_LIM_DB;
wire lim_free = limit_stop_select == `SMS_LIM_FREE;
wire lim_estop = limit_stop_select == `SMS_LIM_ESTOP;

always_comb begin
	next_state = state;
	case (state)
		sms_pkg::SMS_RUN: begin
			if (pwr_stop) begin
				next_state = sms_pkg::SMS_DECEL;
			end
		end
		sms_pkg::SMS_DECEL: begin
			if (!pwr_stop) begin
				next_state = sms_pkg::SMS_RUN;
			end else if (motor_stopped) begin
				next_state = sms_pkg::SMS_STOPPED;
			end
		end
		sms_pkg::SMS_STOPPED: begin
			if (!pwr_stop) begin
				next_state = sms_pkg::SMS_RUN;
			end
		end
		default: begin
			next_state = sms_pkg::SMS_RUN;
		end
	endcase
end

always_comb begin
	next_ctl = '0;
	next_alarm = uv_alarm ? `SMS_ALARM_UV : `SMS_ALARM_NONE;
	next_ctl.fwd_torque_off = fwd_hit;
	next_ctl.rev_torque_off = rev_hit;
	if (limit_hit) begin
		next_ctl.dyn_brake = lim_db;
		next_ctl.torque_off = lim_free;
		next_ctl.estop = lim_estop;
	end
	case (next_state)
		sms_pkg::SMS_DECEL: begin
			next_ctl.estop = pwr_estop;
			next_ctl.dyn_brake = pwr_decel_db;
			next_ctl.torque_off = ~pwr_estop & ~pwr_decel_db;
			next_ctl.dev_clear = ~pwr_hold;
			next_ctl.dev_hold = pwr_hold;
		end
		sms_pkg::SMS_STOPPED: begin
			next_ctl.estop = 1'b0;
			next_ctl.dyn_brake = ~pwr_after_free;
			next_ctl.torque_off = pwr_after_free;
			next_ctl.dev_clear = ~pwr_hold;
			next_ctl.dev_hold = pwr_hold;
		end
		default: begin
			next_ctl.dev_clear = 1'b0;
		end
	endcase
end

always_ff @(posedge clk) begin
	if (rst) begin
		state <= sms_pkg::SMS_RUN;
		ctl <= '0;
		alarm_code <= `SMS_ALARM_NONE;
	end else begin
		state <= next_state;
		ctl <= next_ctl;
		alarm_code <= next_alarm;
	end
end

endmodule : sms_stop_sel
`default_nettype wire

//--- dv/sms_chk.sv
// port checker for the stop mode selector
// assumes a bind from the bench top
`timescale 1ns/10ps
`default_nettype none
module sms_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bus and drive inputs
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic fwd_limit_in,
	input wire logic rev_limit_in,
	input wire logic main_power_lost,
	// stop outputs
	input wire sms_pkg::sms_ctl_t ctl,
	input wire logic [7:0] alarm_code
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
	property p_ans; s_req |=> s_ans; endproperty
	a_ans: assert property (p_ans) else $error("bus answer late");
	property p_fwd; fwd_limit_in |=> ctl.fwd_torque_off; endproperty
	a_fwd: assert property (p_fwd) else $error("fwd torque on");
	property p_rev; rev_limit_in |=> ctl.rev_torque_off; endproperty
	a_rev: assert property (p_rev) else $error("rev torque on");
	property p_uvv; alarm_code != 8'h00 |-> alarm_code == 8'h0d; endproperty
	a_uvv: assert property (p_uvv) else $error("bad alarm");
	property p_uvc; alarm_code != 8'h00 |-> !ctl.dev_clear && !ctl.dev_hold; endproperty
	a_uvc: assert property (p_uvc) else $error("stop with alarm");
	property p_uvd; !main_power_lost |=> alarm_code == 8'h00; endproperty
	a_uvd: assert property (p_uvd) else $error("alarm no loss");
	property p_dev; !(ctl.dev_clear && ctl.dev_hold); endproperty
	a_dev: assert property (p_dev) else $error("clear and hold");
	property p_mode; $onehot0({ctl.dyn_brake, ctl.torque_off, ctl.estop}); endproperty
	a_mode: assert property (p_mode) else $error("two stop modes");
endmodule : sms_chk
`default_nettype wire

//--- dv/sms_motor_model.sv
// motor model: reports rest some cycles after a stop action starts
// assumes ctl from the selector on the same clock
`timescale 1ns/10ps
`default_nettype none
module sms_motor_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// slow coast-down
	input wire logic slow,
	// stop controls and rest flag
	input wire sms_pkg::sms_ctl_t ctl,
	output logic motor_stopped
);
	logic [4:0] cnt;
	wire logic act = ctl.dyn_brake | ctl.torque_off | ctl.estop;
	always_ff @(posedge clk) begin
		cnt <= (rst || !act) ? 5'h0 : cnt + 5'h1;
		motor_stopped <= !(rst || !act) && (motor_stopped || cnt == (slow ? 5'h14 : 5'h3));
	end
endmodule : sms_motor_model
`default_nettype wire

//--- dv/sms_stop_sel_tb.sv
// bench for the stop mode selector
// assumes design, checker and motor model compiled first
`timescale 1ns/10ps
`default_nettype none
bind sms_stop_sel sms_chk u_chk(.clk(clk), .rst(rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .fwd_limit_in(fwd_limit_in),
	.rev_limit_in(rev_limit_in), .main_power_lost(main_power_lost), .ctl(ctl),
	.alarm_code(alarm_code));
module sms_stop_sel_tb;
	logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, f = 1'b0, r = 1'b0, pl = 1'b0;
	logic pc = 1'b0, sl = 1'b0, wq, ms;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0, rdat, q;
	logic [7:0] al;
	sms_pkg::sms_ctl_t c, e;
	int err_count = 0, comparisons = 0, n;
	always #20 clk = ~clk;
	sms_stop_sel uut(.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq), .fwd_limit_in(f),
		.rev_limit_in(r), .main_power_lost(pl), .motor_stopped(ms), .power_cycle(pc),
		.ctl(c), .alarm_code(al));
	sms_motor_model pm(.clk(clk), .rst(rst), .slow(sl), .ctl(c), .motor_stopped(ms));
	task print_verdict();
		if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			err_count++;
			$display("mismatch %0t got %h want %h", $time, g, x);
		end
	endtask : chk
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge clk);
		end while (wq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task rst_dut();
		rst <= 1'b1;
		pl <= 1'b0;
		f <= 1'b0;
		r <= 1'b0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
	endtask : rst_dut
	function sms_pkg::sms_ctl_t pexp(input int s, input bit st);
		sms_pkg::sms_ctl_t x;
		x = '0;
		x.estop = !st && s > 7;
		x.dyn_brake = st ? ((s < 8) ? (s % 4 < 2) : (s == 8)) : (s < 8 && s % 2 == 0);
		x.torque_off = st ? !x.dyn_brake : (s < 8 && s % 2 == 1);
		x.dev_clear = s < 4 || s > 7;
		x.dev_hold = !x.dev_clear;
		return x;
	endfunction : pexp
	initial begin
		n = $urandom(86355);
		for (int s = 0; s < 10; s++) begin
			rst_dut();
			sl <= 1'($urandom % 2);
			bus(1'b1, 4'h0, 32'(s) << 8);
			bus(1'b0, 4'h0, 32'h0);
			chk(q, 32'(s) << 8);
			@(posedge clk) pl <= 1'b1;
			repeat (2) @(posedge clk);
			chk(32'(c), 32'(pexp(s, 1'b0)));
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (ms !== 1'b1 && n < 60);
			@(posedge clk);
			chk(32'(c), 32'(pexp(s, 1'b1)));
		end
		for (int k = 0; k < 4; k++) begin
			rst_dut();
			bus(1'b1, 4'h0, 32'h1 | (32'(k) << 4));
			bus(1'b0, 4'h0, 32'h0);
			chk(q, 32'h1);
			@(posedge clk) pc <= 1'b1;
			@(posedge clk) pc <= 1'b0;
			bus(1'b0, 4'h0, 32'h0);
			chk(q, 32'h1 | (32'(k % 3) << 4));
			n = $urandom % 2;
			f <= n[0];
			r <= !n[0];
			repeat (2) @(posedge clk);
			e = '0;
			e.fwd_torque_off = n[0];
			e.rev_torque_off = !n[0];
			e.dyn_brake = k % 3 == 0;
			e.torque_off = k == 1;
			e.estop = k == 2;
			chk(32'(c), 32'(e));
		end
		rst_dut();
		bus(1'b0, 4'hc, 32'h0);
		chk(q, 32'h0);
		@(posedge clk) pl <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'(al), 32'h0000_000d);
		bus(1'b0, 4'h4, 32'h0);
		chk(q, 32'h0000_000d);
		print_verdict();
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		print_verdict();
	end
endmodule : sms_stop_sel_tb
`default_nettype wire
